//--- src/radio_calibration_control.v
`timescale 1ns/1ps
`include "radio_cal_defs.vh"
// Overview of operation
// - Center-frequency start launches 8 us cycle, self-clears.
// - Center-frequency start reads zero when idle.
// - Delay-cell start launches 6 us cycle, self-clears.
// - Delay-cell start reads zero after; bit6 read-only.
// - Test overrides act only with power-management enable.
// - Chip source override picks manual chip value.
// - Direction pick selects receive or transmit frequency.
// - Direction override applies direction pick.
// - Entering off state from sleep starts filter tuning; leaving reset does not.
// - Filter start launches 25 us cycle, self-clears.
// - Filter start reads zero when finished.
// - Six-bit tuning value resets 0x18, feeds loops.
// - Calibration is not blocked in receive or transmit.
// - Both synthesizer calibrations may run together.
module radio_calibration_control #(
   parameter CF_CYCLES = `CF_CYCLES,
   parameter DC_CYCLES = `DC_CYCLES,
   parameter FT_CYCLES = `FT_CYCLES
) (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       ce_i,
   input  wire       wr_i,
   input  wire       rd_i,
   input  wire [5:0] addr_i,
   input  wire [7:0] wdata_i,
   output reg  [7:0] rdata_o,
   input  wire       power_management_enable_i,
   input  wire       enter_off_from_sleep_i,
   input  wire       normal_chip_i,
   input  wire       normal_dir_tx_i,
   output reg        chip_o,
   output reg        dir_tx_o,
   output reg  [5:0] filter_tuning_value_o,
   output reg        cf_cal_busy_o,
   output reg        dc_cal_busy_o,
   output reg        ft_cal_busy_o
);
   reg  [6:0] cf_low_r;
   reg  [6:0] ft_low_r;
   reg  [6:0] dc_low_r;
   reg  [7:0] tst_r;
   reg  [7:0] rdata_nxt;
   reg        chip_nxt;
   reg        dir_nxt;
   wire       enter_off_s;
   wire       pme_s;
   wire       wr_cf;
   wire       wr_ft;
   wire       wr_dc;
   wire       wr_tst;
   wire       rd_take;
   wire       cf_start;
   wire       dc_start;
   wire       ft_start;
   wire [2:0] cal_start;
   wire [2:0] cal_busy;
   wire       cf_busy;
   wire       dc_busy;
   wire       ft_busy;
   wire [7:0] cf_view;
   wire [7:0] ft_view;
   wire [7:0] dc_view;
   wire [7:0] tst_view;
   wire       chip_ovr_on;
   wire       dir_ovr_on;

   localparam CH_CF = 0;
   localparam CH_DC = 1;
   localparam CH_FT = 2;

   // Both levels come from another domain; only the second flop is read.
   sync2 u_sync_off (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (enter_off_from_sleep_i),
      .q_o   (enter_off_s)
   );

   sync2 u_sync_pme (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (power_management_enable_i),
      .q_o   (pme_s)
   );

   // A write or read only lands while the clock enable runs.
   assign wr_cf   = ce_i && wr_i && (addr_i == `CF_CAL_ADDR);
   assign wr_ft   = ce_i && wr_i && (addr_i == `FT_CTRL_ADDR);
   assign wr_dc   = ce_i && wr_i && (addr_i == `DC_CAL_ADDR);
   assign wr_tst  = ce_i && wr_i && (addr_i == `TST_ADDR);
   assign rd_take = ce_i && rd_i;

   // Only a one in the start bit launches; zero is inert.
   assign cf_start = wr_cf && wdata_i[`START_BIT];
   assign dc_start = wr_dc && wdata_i[`START_BIT];
   // Manual or automatic launch; radio state never gates it.
   assign ft_start = (wr_ft && wdata_i[`START_BIT]) || enter_off_s;

   assign cal_start[CH_CF] = cf_start;
   assign cal_start[CH_DC] = dc_start;
   assign cal_start[CH_FT] = ft_start;

   // Independent timers let both synthesizer cycles overlap.
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_cal
         localparam integer CYC = (g == CH_CF) ? CF_CYCLES :
                                  (g == CH_DC) ? DC_CYCLES : FT_CYCLES;
         cal_timer #(
            .CNT_W  (`CNT_W),
            .CYCLES (CYC)
         ) u_timer (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .ce_i    (ce_i),
            .start_i (cal_start[g]),
            .busy_o  (cal_busy[g]),
            .done_o  ()
         );
      end
   endgenerate

   assign cf_busy = cal_busy[CH_CF];
   assign dc_busy = cal_busy[CH_DC];
   assign ft_busy = cal_busy[CH_FT];

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cf_low_r <= `CF_CAL_RST;
      end else if (wr_cf) begin
         cf_low_r <= wdata_i[6:0];
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ft_low_r <= `FT_CTRL_RST;
      end else if (wr_ft) begin
         ft_low_r <= wdata_i[6:0];
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dc_low_r <= `DC_CAL_RST;
      end else if (wr_dc) begin
         // Bit 6 stays at its reset value.
         dc_low_r <= {dc_low_r[6], wdata_i[5:0]};
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tst_r <= `TST_RST;
      end else if (wr_tst) begin
         tst_r <= wdata_i;
      end
   end

   // Start bits mirror busy, so they read zero when idle.
   assign cf_view  = {cf_busy, cf_low_r};
   assign ft_view  = {ft_busy, ft_low_r};
   assign dc_view  = {dc_busy, dc_low_r};
   assign tst_view = tst_r;

   always @* begin
      rdata_nxt = 8'h00;
      if (addr_i == `CF_CAL_ADDR) begin
         rdata_nxt = cf_view;
      end else if (addr_i == `FT_CTRL_ADDR) begin
         rdata_nxt = ft_view;
      end else if (addr_i == `DC_CAL_ADDR) begin
         rdata_nxt = dc_view;
      end else if (addr_i == `TST_ADDR) begin
         rdata_nxt = tst_view;
      end
   end

   // Overrides count only with power management on.
   assign chip_ovr_on = pme_s && tst_r[`CHIP_SRC_BIT];
   assign dir_ovr_on  = pme_s && tst_r[`DIR_OVR_BIT];

   always @* begin
      chip_nxt = normal_chip_i;
      if (chip_ovr_on) begin
         chip_nxt = tst_r[`CHIP_VAL_BIT];
      end
   end

   always @* begin
      dir_nxt = normal_dir_tx_i;
      if (dir_ovr_on) begin
         dir_nxt = tst_r[`DIR_PICK_BIT];
      end
   end

   // Read data holds between reads so a slow host may fetch it late.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_take) begin
         rdata_o <= rdata_nxt;
      end
   end

   // Registered outputs cost a cycle but keep decode glitches off pins.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         chip_o <= 1'b0;
      end else if (ce_i) begin
         chip_o <= chip_nxt;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dir_tx_o <= 1'b0;
      end else if (ce_i) begin
         dir_tx_o <= dir_nxt;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         filter_tuning_value_o <= `FTV_RST;
      end else if (ce_i) begin
         filter_tuning_value_o <= ft_low_r[5:0];
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cf_cal_busy_o <= 1'b0;
      end else if (ce_i) begin
         cf_cal_busy_o <= cf_busy;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dc_cal_busy_o <= 1'b0;
      end else if (ce_i) begin
         dc_cal_busy_o <= dc_busy;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ft_cal_busy_o <= 1'b0;
      end else if (ce_i) begin
         ft_cal_busy_o <= ft_busy;
      end
   end
endmodule

//--- src/radio_cal_defs.vh
`ifndef RADIO_CAL_DEFS_VH
`define RADIO_CAL_DEFS_VH
`define CF_CAL_ADDR      6'h1a
`define FT_CTRL_ADDR     6'h18
`define DC_CAL_ADDR      6'h1b
`define TST_ADDR         6'h3d
`define START_BIT        7
`define CF_CAL_RST       7'h57
`define FT_CTRL_RST      7'h58
`define FTV_RST          6'h18
`define DC_CAL_RST       7'h20
`define DC_RO_BIT        6
`define TST_RST          8'h00
`define CHIP_SRC_BIT     7
`define CHIP_VAL_BIT     6
`define DIR_PICK_BIT     5
`define DIR_OVR_BIT      4
`define CLK_MHZ          125
`define T_CF_NS          8000
`define T_DC_NS          6000
`define T_FT_NS          25000
`define CF_CYCLES        ((`T_CF_NS * `CLK_MHZ) / 1000)
`define DC_CYCLES        ((`T_DC_NS * `CLK_MHZ) / 1000)
`define FT_CYCLES        ((`T_FT_NS * `CLK_MHZ) / 1000)
`define CNT_W            13
`endif

//--- src/cal_timer.v
`timescale 1ns/1ps
module cal_timer #(
   parameter CNT_W  = 13,
   parameter CYCLES = 1000
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             ce_i,
   input  wire             start_i,
   output reg              busy_o,
   output reg              done_o
);
   localparam [31:0]      LAST_FULL = CYCLES - 1;
   localparam [CNT_W-1:0] LAST      = LAST_FULL[CNT_W-1:0];
   reg [CNT_W-1:0] cnt_r;
   // A start while busy is ignored so an active cycle is never restarted.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r  <= {CNT_W{1'b0}};
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (!busy_o) begin
            if (start_i) begin
               busy_o <= 1'b1;
               cnt_r  <= {CNT_W{1'b0}};
            end
         end else if (cnt_r == LAST) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule

//--- src/sync2.v
`timescale 1ns/1ps
module sync2 (
   input  wire clk_i,
   input  wire rst_i,
   input  wire ce_i,
   input  wire d_i,
   output reg  q_o
);
   reg meta_r;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         q_o    <= 1'b0;
      end else if (ce_i) begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule

//--- testbench/radio_cal_chk.sv
`timescale 1ns/1ps
module radio_cal_chk #(
   parameter CF_CYCLES = 4,
   parameter DC_CYCLES = 4,
   parameter FT_CYCLES = 4
) (
   input logic clk_i, rst_i, ce_i, wr_i, rd_i,
   input logic [5:0] addr_i,
   input logic [7:0] wdata_i, rdata_o,
   input logic power_management_enable_i, enter_off_from_sleep_i,
   input logic normal_chip_i, normal_dir_tx_i, chip_o, dir_tx_o,
   input logic cf_cal_busy_o, dc_cal_busy_o, ft_cal_busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire go = ce_i && wr_i && wdata_i[7];
   int ccf, cdc, cft;
   // Busy lengths are counted so the parameters need no unrolling.
   // Frozen cycles are not counted, since the timers do not run then.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ccf <= 0;
         cdc <= 0;
         cft <= 0;
      end else begin
         ccf <= !cf_cal_busy_o ? 0 : ce_i ? ccf + 1 : ccf;
         cdc <= !dc_cal_busy_o ? 0 : ce_i ? cdc + 1 : cdc;
         cft <= !ft_cal_busy_o ? 0 : ce_i ? cft + 1 : cft;
      end
   end
   property p_cf_go;
      go && addr_i == 6'h1a && !cf_cal_busy_o |-> ##[1:3] cf_cal_busy_o;
   endproperty
   a_cf_go: assert property (p_cf_go) else $error("cf start lost");
   property p_dc_go;
      go && addr_i == 6'h1b && !dc_cal_busy_o |-> ##[1:3] dc_cal_busy_o;
   endproperty
   a_dc_go: assert property (p_dc_go) else $error("dc start lost");
   property p_ft_go;
      go && addr_i == 6'h18 && !ft_cal_busy_o |-> ##[1:3] ft_cal_busy_o;
   endproperty
   a_ft_go: assert property (p_ft_go) else $error("ft start lost");
   property p_cf_len;
      $fell(cf_cal_busy_o) |-> ccf == CF_CYCLES;
   endproperty
   a_cf_len: assert property (p_cf_len) else $error("cf length");
   property p_dc_len;
      $fell(dc_cal_busy_o) |-> cdc == DC_CYCLES;
   endproperty
   a_dc_len: assert property (p_dc_len) else $error("dc length");
   property p_ft_len;
      $fell(ft_cal_busy_o) |-> cft == FT_CYCLES;
   endproperty
   a_ft_len: assert property (p_ft_len) else $error("ft length");
   property p_auto;
      ce_i && enter_off_from_sleep_i && !ft_cal_busy_o
         |-> ##[1:6] ft_cal_busy_o;
   endproperty
   a_auto: assert property (p_auto) else $error("auto tune lost");
   property p_pmu_off;
      !power_management_enable_i [*5] |-> {chip_o, dir_tx_o} ==
         {$past(normal_chip_i), $past(normal_dir_tx_i)};
   endproperty
   a_pmu_off: assert property (p_pmu_off) else $error("override leak");
   property p_unmapped;
      ce_i && rd_i && addr_i == 6'h00 |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind radio_calibration_control radio_cal_chk #(.CF_CYCLES(CF_CYCLES),
   .DC_CYCLES(DC_CYCLES), .FT_CYCLES(FT_CYCLES)) u_chk (.clk_i, .rst_i,
   .ce_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
   .power_management_enable_i, .enter_off_from_sleep_i, .normal_chip_i,
   .normal_dir_tx_i, .chip_o, .dir_tx_o, .cf_cal_busy_o, .dc_cal_busy_o,
   .ft_cal_busy_o);

//--- testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
   input  logic       clk_i,
   input  logic [7:0] rdata_i,
   output logic       wr_o = 1'b0,
   output logic       rd_o = 1'b0,
   output logic [5:0] addr_o = 6'h00,
   output logic [7:0] wdata_o = 8'h00
);
   // Manual tuning starts only from idle states, well within any
   // interval.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1 d = rdata_i;
   endtask
endmodule

//--- testbench/radio_calibration_control_tb_top.sv
`timescale 1ns/1ps
module radio_calibration_control_tb_top;
   localparam CF = 16, DC = 12, FT = 8;
   logic clk_i = 1'b0, rst_i = 1'b1, pme = 1'b0, eoff = 1'b0;
   logic nchip = 1'b0, ndir = 1'b0, ce = 1'b1, wr, rd, chip, dir, cfb, dcb;
   logic ftb;
   logic [5:0] addr, ftv;
   logic [7:0] wdata, rdata, v, t;
   logic [31:0] seed = 32'd51;
   int n_errors = 0, comparisons = 0;
   always #4 clk_i = ~clk_i;
   host_model u_host (.clk_i, .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata));
   radio_calibration_control #(.CF_CYCLES(CF), .DC_CYCLES(DC),
      .FT_CYCLES(FT)) u_dut (.clk_i, .rst_i, .ce_i(ce), .wr_i(wr),
      .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .power_management_enable_i(pme), .enter_off_from_sleep_i(eoff),
      .normal_chip_i(nchip), .normal_dir_tx_i(ndir), .chip_o(chip),
      .dir_tx_o(dir), .filter_tuning_value_o(ftv), .cf_cal_busy_o(cfb),
      .dc_cal_busy_o(dcb), .ft_cal_busy_o(ftb));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] exp_out(input logic p, input logic [7:0] r);
      return {6'h00, p && r[7] ? r[6] : nchip, p && r[4] ? r[5] : ndir};
   endfunction
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input logic [7:0] e,
                       input string n);
      u_host.rd(a, v);
      chk(n, e, v);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #40000;
      n_errors++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(6'h1a, 8'h57, "cf reset");
      rchk(6'h1b, 8'h20, "dc reset");
      rchk(6'h18, 8'h58, "ft reset");
      rchk(6'h3d, 8'h00, "tst reset");
      rchk(6'h00, 8'h00, "unmapped");
      chk("ftv reset", 8'h18, {2'b00, ftv});
      $display("reset test done");
      u_host.wr(6'h1a, 8'hd7);
      u_host.wr(6'h1b, 8'hff);
      u_host.wr(6'h1a, 8'h57);
      u_host.wr(6'h1a, 8'hd7);
      rchk(6'h1a, 8'hd7, "cf busy");
      rchk(6'h1b, 8'hbf, "dc busy");
      repeat (30) @(posedge clk_i);
      rchk(6'h1a, 8'h57, "cf done");
      rchk(6'h1b, 8'h3f, "dc done");
      // A frozen clock enable must stretch the cycle by the frozen span.
      u_host.wr(6'h1a, 8'hd7);
      repeat (4) @(posedge clk_i);
      ce <= 1'b0;
      repeat (CF + 4) @(posedge clk_i);
      #1 chk("frozen busy", 8'h01, {7'h00, cfb});
      @(posedge clk_i) ce <= 1'b1;
      rchk(6'h1a, 8'hd7, "cf after freeze");
      repeat (CF) @(posedge clk_i);
      rchk(6'h1a, 8'h57, "cf done after freeze");
      $display("freeze test done");
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         t = i == 0 ? 8'hbf : i == 1 ? 8'h80 : {2'b10, seed[5:0]};
         u_host.wr(6'h18, t);
         rchk(6'h18, t, "ft busy");
         repeat (FT + 4) @(posedge clk_i);
         rchk(6'h18, t & 8'h3f, "ft done");
         chk("ftv", t & 8'h3f, {2'b00, ftv});
      end
      $display("calibration test done");
      @(posedge clk_i) eoff <= 1'b1;
      repeat (3) @(posedge clk_i);
      eoff <= 1'b0;
      for (int k = 0; k < 8 && ftb !== 1'b1; k++) @(posedge clk_i);
      chk("auto tune", 8'h01, {7'h00, ftb});
      repeat (FT + 6) @(posedge clk_i);
      for (int i = 0; i < 32; i++) begin
         seed = xs(seed);
         @(posedge clk_i);
         pme <= i[4];
         nchip <= seed[0];
         ndir <= seed[1];
         u_host.wr(6'h3d, {i[3:0], seed[5:2]});
         repeat (5) @(posedge clk_i);
         #1 chk("outputs", exp_out(pme, {i[3:0], 4'h0}),
                {6'h00, chip, dir});
         rchk(6'h3d, {i[3:0], seed[5:2]}, "tst rw");
      end
      $display("override test done");
      close_out();
   end
endmodule
